// ### design/grf_params.svh
//==========================================================================
// Purpose: Constants for the gyro rate, filter and sync configuration block
// Assumes: 100 MHz mclk_i, APB register access, one word per register
// Notes:   Offsets are register indexes; byte address is four times index
//
// Overview of operation
// - Z offset high register holds bits 15:8
// - Z offset low register holds bits 7:0
// - Add combined offset to raw Z sample
// - Output rate is 1 kHz over divisor+1
// - Output rate paces result updates and queue
// - Divisor used only in select 00, lowpass 1-6
// - Full queue: policy 1 drops, 0 overwrites
// - Sync target picks which result LSB carries sync
// - Sync latched, toggles once until strobe captures
// - Lowpass select applies only when bypass select 00
// - Gyro and temperature filters follow both selects
// - Gyro rate 32k, 8k or divided per selects
// - Temperature bandwidth 188..5 Hz for lowpass 1-6
//==========================================================================
`ifndef GRF_PARAMS_SVH
`define GRF_PARAMS_SVH

// Register indexes
`define GRF_IDX_ZOFS_HIGH 10'h017
`define GRF_IDX_ZOFS_LOW 10'h018
`define GRF_IDX_RATE_DIV 10'h019
`define GRF_IDX_CONFIG 10'h01a

// Reset values
`define GRF_RST_ZOFS 8'h00
`define GRF_RST_RATE_DIV 8'h00
`define GRF_RST_CONFIG 8'h80

// Config field positions
`define GRF_CFG_POLICY_BIT 6
`define GRF_CFG_TARGET_HI 5
`define GRF_CFG_TARGET_LO 3
`define GRF_CFG_LPS_HI 2
`define GRF_CFG_LPS_LO 0

// Sync target code that lands on the Z gyro result
`define GRF_TARGET_GYRO_Z 3'h4

// Timing, in nanoseconds
`define GRF_CLK_PERIOD_NS 10
`define GRF_BASE_PERIOD_NS 1000000
`define GRF_MID_PERIOD_NS 125000
`define GRF_FAST_PERIOD_NS 31250

`endif

// ### design/grf_pkg.sv
//==========================================================================
// Purpose: Types for the gyro rate, filter and sync configuration block
// Assumes: Constants live in grf_params.svh
// Notes:   Rate mode picks the internal gyro sample rate
//==========================================================================
package grf_pkg;
  // Internal sample rate chosen by the filter selects
  typedef enum logic [1:0] {
    GRF_RATE_FAST,
    GRF_RATE_MID,
    GRF_RATE_DIV
  } grf_rate_e;
  // Gyro filter code: 0..7 lowpass, 8 wide 3600 Hz, 9 bypass 8800 Hz
  typedef logic [3:0] grf_filt_t;
endpackage : grf_pkg

// ### design/grf_rate_filter_cfg.sv
//==========================================================================
// Purpose: APB register bank, sample pacing, Z offset and sync tagging
// Assumes: APB master keeps request stable until pready; inputs synchronous except the frame sync pin
// Notes:   Long rate counts are parameters so simulation can shorten them
//==========================================================================
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/10ps
`include "grf_params.svh"

module grf_rate_filter_cfg #(
  parameter int BASE_CYCLES = `GRF_BASE_PERIOD_NS / `GRF_CLK_PERIOD_NS, // 1 kHz tick
  parameter int MID_CYCLES = `GRF_MID_PERIOD_NS / `GRF_CLK_PERIOD_NS,   // 8 kHz tick
  parameter int ADDR_W = 12                                           // APB address
)(
  input wire logic mclk_i,                    // System clock
  input wire logic reset_n_i,                 // Sync reset, active low
  input wire logic psel_i,                    // APB select
  input wire logic penable_i,                 // APB enable
  input wire logic pwrite_i,                  // APB direction
  input wire logic [ADDR_W-1:0] paddr_i,      // APB byte address
  input wire logic [31:0] pwdata_i,           // APB write data
  output logic pready_o,                      // APB ready
  output logic [31:0] prdata_o,               // APB read data
  output logic pslverr_o,                     // APB error, unmapped address
  input wire logic [1:0] filter_bypass_sel_i, // Bypass select from gyro config
  input wire logic [15:0] raw_gyro_z_i,       // Raw Z gyro sample
  input wire logic frame_sync_input_i,        // External frame sync pin
  input wire logic queue_full_i,              // Sample queue is full
  output logic sample_strobe_o,               // One pulse per output sample
  output logic [15:0] gyro_z_result_o,        // Offset corrected Z result
  output logic queue_write_o,                 // Push sample into queue
  output logic queue_overwrite_o,             // Push replaces oldest entry
  output logic [2:0] frame_sync_target_o,     // Which result LSB is tagged
  output logic frame_sync_tag_o,              // Captured sync level
  output grf_pkg::grf_rate_e rate_mode_o,     // Internal gyro rate mode
  output grf_pkg::grf_filt_t gyro_filter_o,   // Gyro filter code
  output logic [2:0] temp_filter_o            // Temp filter, 0 none
);
  import grf_pkg::*;

  localparam int FAST_CYCLES = `GRF_FAST_PERIOD_NS / `GRF_CLK_PERIOD_NS; // 32 kHz

  //========================================================================
  // Register bank and APB slave
  //========================================================================
  logic [7:0] zofs_high_q, zofs_high_d;   // Offset bits 15:8
  logic [7:0] zofs_low_q, zofs_low_d;     // Offset bits 7:0
  logic [7:0] rate_div_q, rate_div_d;     // Rate divisor
  logic [7:0] config_q, config_d;         // Filter and sync config
  logic pready_q, pready_d;               // Ready flop
  logic [31:0] prdata_q, prdata_d;        // Read data flop
  logic pslverr_q, pslverr_d;             // Error flop
  logic [9:0] idx_w;                      // Word index of access
  logic setup_w;                          // Setup phase seen
  logic wr_done_w;                        // Write completes this edge
  logic hit_w;                            // Address maps to a register
  logic [7:0] rd_w;                       // Selected read byte

  assign idx_w = paddr_i[11:2];
  assign setup_w = psel_i && !penable_i;
  assign wr_done_w = psel_i && penable_i && pready_q && pwrite_i;

  // Decode and next values of the bank
  always_comb
  begin
    zofs_high_d = zofs_high_q;
    zofs_low_d = zofs_low_q;
    rate_div_d = rate_div_q;
    config_d = config_q;
    hit_w = 1'b1;
    rd_w = 8'h00;
    case (idx_w)
      `GRF_IDX_ZOFS_HIGH: rd_w = zofs_high_q;
      `GRF_IDX_ZOFS_LOW: rd_w = zofs_low_q;
      `GRF_IDX_RATE_DIV: rd_w = rate_div_q;
      `GRF_IDX_CONFIG: rd_w = config_q;
      default: hit_w = 1'b0;
    endcase
    if (wr_done_w)
    begin
      case (idx_w)
        `GRF_IDX_ZOFS_HIGH: zofs_high_d = pwdata_i[7:0];
        `GRF_IDX_ZOFS_LOW: zofs_low_d = pwdata_i[7:0];
        `GRF_IDX_RATE_DIV: rate_div_d = pwdata_i[7:0];
        `GRF_IDX_CONFIG: config_d = pwdata_i[7:0];
        default: ;                                       // Unmapped write dropped
      endcase
    end
    // Answer one cycle after setup; data and error ready with it
    pready_d = setup_w;
    prdata_d = setup_w ? {24'h000000, rd_w} : prdata_q;
    pslverr_d = setup_w ? !hit_w : 1'b0;
  end

  // Bank flops
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      zofs_high_q <= `GRF_RST_ZOFS;
      zofs_low_q <= `GRF_RST_ZOFS;
      rate_div_q <= `GRF_RST_RATE_DIV;
      config_q <= `GRF_RST_CONFIG;
      pready_q <= 1'b0;
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      zofs_high_q <= zofs_high_d;
      zofs_low_q <= zofs_low_d;
      rate_div_q <= rate_div_d;
      config_q <= config_d;
      pready_q <= pready_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign pready_o = pready_q;
  assign prdata_o = prdata_q;
  assign pslverr_o = pslverr_q;

  //========================================================================
  // Filter selection and rate pacing
  //========================================================================
  logic [2:0] lps_w;                      // Lowpass select field
  logic policy_w;                         // Queue full policy
  grf_rate_e mode_w;                      // Rate mode from selects
  grf_filt_t gfilt_w;                     // Gyro filter code
  logic [2:0] tfilt_w;                    // Temp filter code
  logic [16:0] per_m1_w;                  // Tick period minus one
  logic [16:0] cnt_q, cnt_d;              // Tick counter
  logic [7:0] div_q, div_d;               // Divider counter
  logic tick_w;                           // Internal rate tick
  logic strobe_w;                         // Output sample strobe
  grf_rate_e mode_q;                      // Registered rate mode
  grf_filt_t gfilt_q;                     // Registered gyro filter
  logic [2:0] tfilt_q;                    // Registered temp filter

  assign lps_w = config_q[`GRF_CFG_LPS_HI:`GRF_CFG_LPS_LO];
  assign policy_w = config_q[`GRF_CFG_POLICY_BIT];

  // Mode, filter codes and pacing next state
  always_comb
  begin
    // Bypass selects override the lowpass field
    if (filter_bypass_sel_i[0])
    begin
      mode_w = GRF_RATE_FAST;
      gfilt_w = 4'h9;
    end
    else if (filter_bypass_sel_i[1])
    begin
      mode_w = GRF_RATE_FAST;
      gfilt_w = 4'h8;
    end
    else
    begin
      gfilt_w = {1'b0, lps_w};
      mode_w = (lps_w == 3'h0 || lps_w == 3'h7) ? GRF_RATE_MID : GRF_RATE_DIV;
    end
    // Temperature path has a filter only for lowpass 1..6
    tfilt_w = (filter_bypass_sel_i == 2'b00 && lps_w != 3'h7) ? lps_w : 3'h0;
    case (mode_w)
      GRF_RATE_FAST: per_m1_w = 17'(FAST_CYCLES - 1);
      GRF_RATE_MID: per_m1_w = 17'(MID_CYCLES - 1);
      default: per_m1_w = 17'(BASE_CYCLES - 1);
    endcase
    tick_w = (cnt_q >= per_m1_w);
    cnt_d = tick_w ? 17'h00000 : cnt_q + 17'h00001;
    div_d = div_q;
    strobe_w = tick_w;
    if (mode_w == GRF_RATE_DIV)
    begin
      // Strobe on every (divisor+1)-th 1 kHz tick
      strobe_w = tick_w && (div_q >= rate_div_q);
      if (tick_w)
        div_d = strobe_w ? 8'h00 : div_q + 8'h01;
    end
    else
      div_d = 8'h00;
  end

  // Pacing flops
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      cnt_q <= 17'h00000;
      div_q <= 8'h00;
      mode_q <= GRF_RATE_MID;
      gfilt_q <= 4'h0;
      tfilt_q <= 3'h0;
    end
    else
    begin
      cnt_q <= cnt_d;
      div_q <= div_d;
      mode_q <= mode_w;
      gfilt_q <= gfilt_w;
      tfilt_q <= tfilt_w;
    end
  end

  assign rate_mode_o = mode_q;
  assign gyro_filter_o = gfilt_q;
  assign temp_filter_o = tfilt_q;

  //========================================================================
  // Frame sync capture
  //========================================================================
  logic sync1_q, sync2_q, sync3_q;        // Synchroniser and edge history
  logic latch_q, latch_d;                 // Latched sync level
  logic pend_q, pend_d;                   // Toggle waiting for capture
  logic edge_w;                           // Input toggled

  assign edge_w = sync2_q ^ sync3_q;

  // Latch toggles once per capture window; a toggle in the capture cycle
  // stays pending, so it can not be toggled away before it is captured
  always_comb
  begin
    latch_d = latch_q;
    pend_d = pend_q;
    if (strobe_w)
      pend_d = 1'b0;
    if (edge_w && (!pend_q || strobe_w))
    begin
      latch_d = !latch_q;
      pend_d = 1'b1;                        // Set wins over the capture clear
    end
  end

  // Sync flops
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      latch_q <= 1'b0;
      pend_q <= 1'b0;
    end
    else
    begin
      sync1_q <= frame_sync_input_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      latch_q <= latch_d;
      pend_q <= pend_d;
    end
  end

  //========================================================================
  // Result update and queue push
  //========================================================================
  logic [15:0] sum_w;                     // Raw plus user offset
  logic [2:0] target_w;                   // Sync target field
  logic [15:0] res_q, res_d;              // Result flop
  logic stb_q;                            // Strobe flop
  logic qw_q, qw_d;                       // Queue push flop
  logic qo_q, qo_d;                       // Queue overwrite flop
  logic tag_q, tag_d;                     // Captured sync flop
  logic [2:0] tgt_q;                      // Target flop

  assign sum_w = raw_gyro_z_i + {zofs_high_q, zofs_low_q};
  assign target_w = config_q[`GRF_CFG_TARGET_HI:`GRF_CFG_TARGET_LO];

  // Next result, tag and queue request
  always_comb
  begin
    res_d = res_q;
    tag_d = tag_q;
    qw_d = 1'b0;
    qo_d = 1'b0;
    if (strobe_w)
    begin
      res_d = sum_w;
      tag_d = latch_q;
      if (target_w == `GRF_TARGET_GYRO_Z)
        res_d[0] = latch_q;
      qw_d = !(policy_w && queue_full_i);
      qo_d = !policy_w && queue_full_i;
    end
  end

  // Result flops
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      res_q <= 16'h0000;
      stb_q <= 1'b0;
      qw_q <= 1'b0;
      qo_q <= 1'b0;
      tag_q <= 1'b0;
      tgt_q <= 3'h0;
    end
    else
    begin
      res_q <= res_d;
      stb_q <= strobe_w;
      qw_q <= qw_d;
      qo_q <= qo_d;
      tag_q <= tag_d;
      tgt_q <= target_w;
    end
  end

  assign sample_strobe_o = stb_q;
  assign gyro_z_result_o = res_q;
  assign queue_write_o = qw_q;
  assign queue_overwrite_o = qo_q;
  assign frame_sync_tag_o = tag_q;
  assign frame_sync_target_o = tgt_q;

  //========================================================================
  // Checks
  //========================================================================
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  ready_after_setup_a: assert property (setup_w |=> pready_o && !$past(pready_o))
    else $error("pready not given one cycle after setup");
  offset_high_store_a: assert property (wr_done_w && idx_w == `GRF_IDX_ZOFS_HIGH |=>
    zofs_high_q == $past(pwdata_i[7:0]))
    else $error("offset high byte not stored");
  offset_low_store_a: assert property (wr_done_w && idx_w == `GRF_IDX_ZOFS_LOW |=>
    zofs_low_q == $past(pwdata_i[7:0]))
    else $error("offset low byte not stored");
  offset_sum_a: assert property (strobe_w |=> gyro_z_result_o[15:1] == $past(sum_w[15:1]))
    else $error("result is not raw plus offset");
  fixed_rate_a: assert property (tick_w && mode_w != GRF_RATE_DIV |=> sample_strobe_o)
    else $error("divider applied outside divided mode");
  divider_skip_a: assert property (mode_w == GRF_RATE_DIV && tick_w && div_q < rate_div_q
    |=> !sample_strobe_o)
    else $error("strobe before divisor reached");
  queue_paced_a: assert property ((queue_write_o || queue_overwrite_o) |-> sample_strobe_o)
    else $error("queue push off the sample strobe");
  queue_drop_a: assert property (strobe_w && queue_full_i && policy_w |=> !queue_write_o)
    else $error("full queue written while dropping");
  queue_over_a: assert property (strobe_w && queue_full_i && !policy_w
    |=> queue_write_o && queue_overwrite_o)
    else $error("full queue not overwritten");
  sync_tag_lsb_a: assert property (sample_strobe_o && frame_sync_target_o == `GRF_TARGET_GYRO_Z
    |-> gyro_z_result_o[0] == frame_sync_tag_o)
    else $error("sync bit missing from Z result");
  latch_hold_a: assert property (pend_q && !strobe_w |=> $stable(latch_q))
    else $error("latched sync toggled twice");
  sync_set_wins_a: assert property (edge_w && strobe_w |=> pend_q)
    else $error("sync toggle in capture cycle lost");
  temp_off_a: assert property (filter_bypass_sel_i != 2'b00 |=>
    temp_filter_o == 3'h0)
    else $error("temperature filter set while bypassed");
  sync_chain_a: assert property (##2 sync2_q == $past(frame_sync_input_i, 2))
    else $error("sync input not two stages deep");
  filter_pass_a: assert property (filter_bypass_sel_i == 2'b00 |=>
    gyro_filter_o == {1'b0, $past(lps_w)})
    else $error("lowpass select not applied");

endmodule : grf_rate_filter_cfg

// ### testbench/grf_host_model.sv
// Purpose: APB host model that programs the rate and filter registers
// Assumes: Slave raises pready_i; the bench watchdog ends any hang
// Notes:   Past the time-zero idle, signals change only by non-blocking assignment after a rising edge
`timescale 1ns/10ps
module grf_host_model (
  input wire logic mclk_i,          // System clock
  input wire logic pready_i,        // Slave ready
  input wire logic [31:0] prdata_i, // Slave read data
  input wire logic pslverr_i,       // Slave error
  output logic psel_o,              // Select
  output logic penable_o,           // Enable
  output logic pwrite_o,            // Direction
  output logic [11:0] paddr_o,      // Byte address
  output logic [31:0] pwdata_o      // Write data
);
  // Idle bus from time zero
  initial
  begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h000;
    pwdata_o = 32'h0;
  end
  //==========================================================================
  // One transfer; the host never runs low power, so any divisor is legal
  task xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
            output logic [31:0] rd, output logic err);
    @(posedge mclk_i);
    psel_o <= 1'b1;
    pwrite_o <= wr;
    paddr_o <= addr;
    pwdata_o <= wd;
    @(posedge mclk_i);
    penable_o <= 1'b1;
    // Hold the request until ready is seen at an edge
    do @(posedge mclk_i); while (pready_i !== 1'b1);
    rd = prdata_i;
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask : xfer
endmodule : grf_host_model

// ### testbench/tb_top.sv
// Purpose: Self-checking bench for the rate, filter and sync block
// Assumes: Short pacing counts, base 20 and mid 10 cycles
// Notes:   Register rows first, then reset, filters, pacing, offset, sync
`timescale 1ns/10ps
`include "grf_params.svh"
module tb_top;
  import grf_pkg::*;
  // Register row: index, write data, read back, error expected
  typedef struct packed {logic [9:0] idx; logic [31:0] wd; logic [7:0] rd; logic er;} grf_row_s;
  logic mclk_i = 1'b0;         // Clock
  logic reset_n_i = 1'b0;      // Reset, active low
  logic psel, penable, pwrite, pready, pslverr; // APB wires
  logic [11:0] paddr;          // APB address
  logic [31:0] pwdata, prdata; // APB data
  logic [1:0] bypass = 2'b00;  // Filter bypass select
  logic [15:0] raw = 16'h0;    // Raw Z sample
  logic sync_pin = 1'b0;       // Frame sync pin
  logic qfull = 1'b0;          // Queue full
  logic strobe, qwr, qovr, tag; // Sample path outputs
  logic [15:0] res;            // Z result
  logic [2:0] tgt, tfilt;      // Target and temp filter
  grf_rate_e mode;             // Rate mode
  grf_filt_t gfilt;            // Gyro filter
  int err_count = 0;           // Mismatches
  int checked = 0;             // Comparisons
  int n;                       // Cycle count
  logic [31:0] rd;             // Read data
  logic er;                    // Read error
  grf_row_s rows [6];          // Register rows
  always #5 mclk_i = ~mclk_i;
  grf_rate_filter_cfg #(.BASE_CYCLES(20), .MID_CYCLES(10)) grf_rate_filter_cfg_inst (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr), .filter_bypass_sel_i(bypass),
    .raw_gyro_z_i(raw), .frame_sync_input_i(sync_pin), .queue_full_i(qfull),
    .sample_strobe_o(strobe), .gyro_z_result_o(res), .queue_write_o(qwr),
    .queue_overwrite_o(qovr), .frame_sync_target_o(tgt), .frame_sync_tag_o(tag),
    .rate_mode_o(mode), .gyro_filter_o(gfilt), .temp_filter_o(tfilt));
  grf_host_model grf_host_model_inst (
    .mclk_i(mclk_i), .pready_i(pready), .prdata_i(prdata), .pslverr_i(pslverr),
    .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
    .pwdata_o(pwdata));
  //==========================================================================
  // Compare one value
  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // Register access by index
  task wreg(input logic [9:0] idx, input logic [31:0] d);
    grf_host_model_inst.xfer(1'b1, {idx, 2'b00}, d, rd, er);
  endtask : wreg
  task rreg(input logic [9:0] idx);
    grf_host_model_inst.xfer(1'b0, {idx, 2'b00}, 32'h0, rd, er);
  endtask : rreg
  // Count cycles up to the next strobe, checked at the falling edge
  task wait_strobe();
    n = 0;
    do
    begin
      @(negedge mclk_i);
      n++;
    end
    while (strobe !== 1'b1 && n < 10000);
    check("strobe_seen", 1, strobe);
  endtask : wait_strobe
  // Strobe period for one select setting
  task period(input logic [1:0] b, input logic [7:0] cfg, input int exp);
    @(posedge mclk_i) bypass <= b;
    wreg(`GRF_IDX_CONFIG, {24'h0, cfg});
    repeat (3) wait_strobe();
    check("period", exp, n);
    check("queue_write", 1, qwr);
  endtask : period
  // Verdict
  task print_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // Watchdog
  initial
  begin
    #500000;
    err_count++;
    print_verdict();
  end
  //==========================================================================
  // Main sequence
  initial
  begin
    rows[0] = '{`GRF_IDX_ZOFS_HIGH, 32'h1a5, 8'ha5, 1'b0};
    rows[1] = '{`GRF_IDX_ZOFS_LOW, 32'h5a, 8'h5a, 1'b0};
    rows[2] = '{`GRF_IDX_RATE_DIV, 32'hff, 8'hff, 1'b0};
    rows[3] = '{`GRF_IDX_CONFIG, 32'h3f, 8'h3f, 1'b0};
    rows[4] = '{10'h01b, 32'h77, 8'h00, 1'b1};
    rows[5] = '{10'h016, 32'h77, 8'h00, 1'b1};
    repeat (3) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    // Register rows: write, read back, unmapped refused
    foreach (rows[i])
    begin
      wreg(rows[i].idx, rows[i].wd);
      check("write_err", rows[i].er, er);
      rreg(rows[i].idx);
      check("read_data", {24'h0, rows[i].rd}, rd);
      check("read_err", rows[i].er, er);
    end
    $display("test registers done");
    // Second reset restores defaults
    @(posedge mclk_i) reset_n_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    rreg(`GRF_IDX_ZOFS_HIGH);
    check("rst_high", 0, rd);
    rreg(`GRF_IDX_RATE_DIV);
    check("rst_div", 0, rd);
    rreg(`GRF_IDX_CONFIG);
    check("rst_config", 32'h80, rd);
    $display("test reset done");
    // Every bypass select against every lowpass select
    for (int b = 0; b < 4; b++)
      for (int l = 0; l < 8; l++)
      begin
        @(posedge mclk_i) bypass <= b[1:0];
        wreg(`GRF_IDX_CONFIG, {29'h0, l[2:0]});
        repeat (3) @(negedge mclk_i);
        check("gyro_filter", b == 0 ? l : (b[0] ? 9 : 8), gfilt);
        check("temp_filter", (b == 0 && l > 0 && l < 7) ? l : 0, tfilt);
        check("rate_mode", b != 0 ? GRF_RATE_FAST :
              ((l > 0 && l < 7) ? GRF_RATE_DIV : GRF_RATE_MID), mode);
      end
    $display("test filters done");
    // Pacing: divided, mid and fast rates, divisor ignored off 1..6
    wreg(`GRF_IDX_RATE_DIV, 32'h2);
    period(2'b00, 8'h01, 60);
    period(2'b00, 8'h07, 10);
    period(2'b10, 8'h00, 3125);
    $display("test pacing done");
    // Offset added with 16-bit wrap, then queue full policies
    @(posedge mclk_i) bypass <= 2'b00;
    raw <= 16'hfffe;
    wreg(`GRF_IDX_ZOFS_HIGH, 32'h01);
    wreg(`GRF_IDX_ZOFS_LOW, 32'h02);
    wreg(`GRF_IDX_CONFIG, 32'h00);
    repeat (2) wait_strobe();
    check("result", 16'h0100, res);
    check("qwr_free", 1, qwr);
    check("qovr_free", 0, qovr);
    @(posedge mclk_i) qfull <= 1'b1;
    repeat (2) wait_strobe();
    check("qwr_over", 1, qwr);
    check("qovr_over", 1, qovr);
    wreg(`GRF_IDX_CONFIG, 32'h40);
    repeat (2) wait_strobe();
    check("qwr_drop", 0, qwr);
    check("qovr_drop", 0, qovr);
    @(posedge mclk_i) qfull <= 1'b0;
    $display("test offset and queue done");
    // Short sync strobes toggle the latch, tagged into the Z result LSB
    wreg(`GRF_IDX_CONFIG, 32'h20);
    repeat (2) wait_strobe();
    check("target", 4, tgt);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge mclk_i) sync_pin <= 1'b1;
      @(posedge mclk_i) sync_pin <= 1'b0;
      wait_strobe();
      check("tag", k == 0, tag);
      check("tag_result", {15'h0080, k == 0}, res);
    end
    // Toggle landing in the capture cycle stays pending for the next strobe
    repeat (7) @(posedge mclk_i);
    sync_pin <= 1'b1;
    @(posedge mclk_i) sync_pin <= 1'b0;
    wait_strobe();
    check("tag_edge_cap", 0, tag);
    wait_strobe();
    check("tag_next_cap", 1, tag);
    $display("test sync done");
    print_verdict();
  end
endmodule : tb_top
